// [core/sarcfg_defines.svh]
// Register offsets, field positions and reset values of the converter
// configuration and result registers.
// Assumes an 8-bit special-function register bus with 8-bit addresses.
`ifndef SARCFG_DEFINES_SVH
`define SARCFG_DEFINES_SVH

`define SARCFG_ADDR_CONFIG 8'hbc
`define SARCFG_ADDR_RES_LOW 8'hbd
`define SARCFG_ADDR_RES_HIGH 8'hbe

`define SARCFG_RST_CONFIG 8'hf9
`define SARCFG_RST_RESULT 8'h00

`define SARCFG_DIV_MSB 7
`define SARCFG_DIV_LSB 3
`define SARCFG_LJST_BIT 2
`define SARCFG_EIGHT_BIT 1
`define SARCFG_GAIN_BIT 0

`define SARCFG_BITS_TEN 4'ha
`define SARCFG_BITS_EIGHT 4'h8
`define SARCFG_BYTE_BITS 8
`define SARCFG_SPLIT_BITS 2
`define SARCFG_ZERO_SIX 6'h00
`define SARCFG_ZERO_BYTE 8'h00

`endif

// [core/sarcfg_pkg.sv]
// Types shared by the converter configuration block.
// Assumes the companion defines header for all numeric constants.
package sarcfg_pkg;

  typedef enum logic [1:0]
  {
    SARCFG_FMT_RIGHT10,
    SARCFG_FMT_LEFT10,
    SARCFG_FMT_EIGHT
  } sarcfg_fmt_t;

endpackage : sarcfg_pkg

// [core/sarcfg_top.sv]
// Configuration register, conversion clock divider and result formatting
// for a 10-bit successive-approximation converter.
// Assumes the converter core pulses convDone for one cycle with rawResult
// valid, and that register bus strobes are synchronous to core_clk.
`timescale 1ns/100ps
`include "sarcfg_defines.svh"

// Notes on behaviour
// - Conversion clock equals system clock divided by divisor plus one.
// - Configuration bit 2 chooses right (0) or left (1) justification.
// - Configuration bit 1 chooses 10-bit (0) or 8-bit (1) conversions.
// - Justification select is ignored while 8-bit mode is selected.
// - Configuration bit 0 selects gain 0.5 (0) or gain 1 (1).
// - Right-justified high byte holds two top bits, bits 7:2 zero.
// - Left-justified high byte holds eight most significant result bits.
// - In 8-bit mode the high byte holds the whole 8-bit result.
// - Right-justified low byte holds the eight least significant bits.
// - Left-justified low byte holds two low bits in 7:6, rest zero.
// - In 8-bit mode the low byte reads all zeros.
// - Both result bytes update each time a conversion completes while clkEn is high.
// - An 8-bit conversion needs two fewer conversion-clock cycles.
// - Results are unsigned 10-bit integers before alignment.
module sarcfg_top #(
  parameter int ResultWidth = 10,
  parameter int DivWidth = 5
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWdata,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic convDone,
  input wire logic [ResultWidth-1:0] rawResult,
  output logic conversionClock,
  output logic conversionClockTick,
  output logic inputGainSelect,
  output logic eightBitModeEnable,
  output logic [3:0] conversionBits
);

  // ------------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------------
  localparam int DivFieldWidth = `SARCFG_DIV_MSB - `SARCFG_DIV_LSB + 1;
  logic [7:0] configQ;
  logic [7:0] resultLowQ;
  logic [7:0] resultHighQ;
  logic [DivWidth-1:0] divCountQ;
  logic [DivWidth-1:0] conversionClockDivisor;
  logic leftJustifySelect;
  logic eightBitSel;
  logic wrConfig;
  logic wrLow;
  logic wrHigh;
  sarcfg_pkg::sarcfg_fmt_t fmt;
  logic [7:0] fmtHigh;
  logic [7:0] fmtLow;
  logic [ResultWidth-1:0] code;
  logic [DivFieldWidth-1:0] divField;
  logic divWrap;
  logic divLowHalf;
  logic [7:0] readMux;

  // The field is cut or widened on purpose, so a counter parameter that
  // differs from the field width still elaborates cleanly.
  assign divField = configQ[`SARCFG_DIV_MSB:`SARCFG_DIV_LSB];
  assign conversionClockDivisor = DivWidth'(divField);
  assign leftJustifySelect = configQ[`SARCFG_LJST_BIT];
  assign eightBitSel = configQ[`SARCFG_EIGHT_BIT];

  // ------------------------------------------------------------------
  // Register write decode
  // ------------------------------------------------------------------
  // Writes to unmapped addresses strobe nothing and are simply dropped.
  always_comb
  begin
    wrConfig = 1'b0;
    wrLow = 1'b0;
    wrHigh = 1'b0;
    if (regWrite)
    begin
      unique case (regAddr)
        `SARCFG_ADDR_CONFIG: wrConfig = 1'b1;
        `SARCFG_ADDR_RES_LOW: wrLow = 1'b1;
        `SARCFG_ADDR_RES_HIGH: wrHigh = 1'b1;
        default: wrConfig = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      configQ <= `SARCFG_RST_CONFIG;
    end
    else if (clkEn && wrConfig)
    begin
      configQ <= regWdata;
    end
  end

  // ------------------------------------------------------------------
  // Conversion clock divider
  // ------------------------------------------------------------------
  // The tick marks each conversion-clock period; the square-ish clock is
  // only a level for the analog core, which advances on the tick.
  // Wrap on a compare of at least rather than equal, so a divisor lowered
  // below the running count ends the period at once instead of wrapping
  // through the whole counter range first.
  assign divWrap = divCountQ >= conversionClockDivisor;
  assign divLowHalf = divCountQ >= (conversionClockDivisor >> 1);

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      divCountQ <= '0;
    end
    else if (clkEn)
    begin
      if (divWrap)
      begin
        divCountQ <= '0;
      end
      else
      begin
        divCountQ <= divCountQ + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      conversionClockTick <= 1'b0;
    end
    else if (clkEn)
    begin
      conversionClockTick <= divWrap;
    end
  end

  // Low for the second half of the period; the high half rounds up.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      conversionClock <= 1'b0;
    end
    else if (clkEn)
    begin
      if (divWrap)
      begin
        conversionClock <= 1'b1;
      end
      else if (divLowHalf)
      begin
        conversionClock <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Mode outputs to the converter core
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      inputGainSelect <= 1'b0;
      eightBitModeEnable <= 1'b0;
      conversionBits <= `SARCFG_BITS_TEN;
    end
    else if (clkEn)
    begin
      inputGainSelect <= configQ[`SARCFG_GAIN_BIT];
      eightBitModeEnable <= eightBitSel;
      conversionBits <= eightBitSel ? `SARCFG_BITS_EIGHT : `SARCFG_BITS_TEN;
    end
  end

  // ------------------------------------------------------------------
  // Result formatting
  // ------------------------------------------------------------------
  always_comb
  begin
    if (eightBitSel)
    begin
      fmt = sarcfg_pkg::SARCFG_FMT_EIGHT;
    end
    else if (leftJustifySelect)
    begin
      fmt = sarcfg_pkg::SARCFG_FMT_LEFT10;
    end
    else
    begin
      fmt = sarcfg_pkg::SARCFG_FMT_RIGHT10;
    end
  end

  assign code = rawResult;

  always_comb
  begin
    unique case (fmt)
      sarcfg_pkg::SARCFG_FMT_RIGHT10:
      begin
        fmtHigh =
          {`SARCFG_ZERO_SIX, code[ResultWidth-1 -: `SARCFG_SPLIT_BITS]};
        fmtLow = code[`SARCFG_BYTE_BITS-1:0];
      end
      sarcfg_pkg::SARCFG_FMT_LEFT10:
      begin
        fmtHigh = code[ResultWidth-1 -: `SARCFG_BYTE_BITS];
        fmtLow = {code[`SARCFG_SPLIT_BITS-1:0], `SARCFG_ZERO_SIX};
      end
      sarcfg_pkg::SARCFG_FMT_EIGHT:
      begin
        // The core converts only the eight MSBs, so they sit at the top.
        // whole 8-bit result
        fmtHigh = code[ResultWidth-1 -: `SARCFG_BYTE_BITS];
        fmtLow = `SARCFG_ZERO_BYTE;
      end
      default:
      begin
        fmtHigh = `SARCFG_ZERO_BYTE;
        fmtLow = `SARCFG_ZERO_BYTE;
      end
    endcase
  end

  // A conversion landing in the same cycle as a software write wins,
  // so a finished result is never lost to a stale store.
  // load on completion
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      resultHighQ <= `SARCFG_RST_RESULT;
      resultLowQ <= `SARCFG_RST_RESULT;
    end
    else if (clkEn)
    begin
      if (convDone)
      begin
        resultHighQ <= fmtHigh;
        resultLowQ <= fmtLow;
      end
      else
      begin
        if (wrHigh)
        begin
          resultHighQ <= regWdata;
        end
        if (wrLow)
        begin
          resultLowQ <= regWdata;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------------
  // Unmapped addresses read as zero rather than a stale byte.
  always_comb
  begin
    unique case (regAddr)
      `SARCFG_ADDR_CONFIG: readMux = configQ;
      `SARCFG_ADDR_RES_LOW: readMux = resultLowQ;
      `SARCFG_ADDR_RES_HIGH: readMux = resultHighQ;
      default: readMux = `SARCFG_ZERO_BYTE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regRdata <= `SARCFG_ZERO_BYTE;
    end
    else if (clkEn && regRead)
    begin
      regRdata <= readMux;
    end
  end

endmodule : sarcfg_top

// [tb/sarcfg_chk.sv]
// Port checks for the converter configuration block.
// Assumes a bind to sarcfg_top; config changes only by bus writes.
`timescale 1ns/100ps
module sarcfg_chk #(
  parameter int ResultWidth = 10
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWdata,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic convDone,
  input wire logic [ResultWidth-1:0] rawResult,
  input wire logic conversionClockTick,
  input wire logic inputGainSelect,
  input wire logic eightBitModeEnable,
  input wire logic [3:0] conversionBits
);
  logic [7:0] cfg_q;
  logic [15:0] expWord;
  logic rd;
  logic cfgWr;
  assign rd = clkEn && regRead;
  assign cfgWr = clkEn && regWrite && regAddr == 8'hbc;
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      cfg_q <= 8'hf9;
    else if (cfgWr)
      cfg_q <= regWdata;
  end
  // Eight-bit mode wins over the justify bit, so it is tested first.
  assign expWord = cfg_q[1] ? {rawResult[9:2], 8'h00} :
    cfg_q[2] ? {rawResult, 6'h00} : {6'h00, rawResult};
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  a_gain_follows:
    assert property (cfgWr ##1 clkEn |=>
      inputGainSelect == $past(regWdata[0], 2)) else $error("gain wrong");
  a_eight_follows:
    assert property (cfgWr ##1 clkEn |=>
      eightBitModeEnable == $past(regWdata[1], 2)) else $error("mode wrong");
  a_bits_match:
    assert property (conversionBits == (eightBitModeEnable ? 4'h8 : 4'ha))
    else $error("bit count wrong");
  a_high_format:
    assert property (convDone && clkEn ##1 rd && regAddr == 8'hbe |=>
      regRdata == $past(expWord[15:8], 2)) else $error("high byte wrong");
  a_low_format:
    assert property (convDone && clkEn ##1 rd ##1 rd && regAddr == 8'hbd
      |=> regRdata == $past(expWord[7:0], 3)) else $error("low byte wrong");
  a_config_read:
    assert property (rd && regAddr == 8'hbc |=> regRdata == $past(cfg_q))
    else $error("config read wrong");
  a_tick_single:
    assert property (conversionClockTick && clkEn && cfg_q[7:3] != 5'h00
      |=> !conversionClockTick) else $error("tick too long");
  a_tick_period:
    assert property (conversionClockTick && clkEn && cfg_q[7:3] == 5'h03
      ##1 clkEn [*3] |=> conversionClockTick) else $error("tick late");
endmodule : sarcfg_chk

bind sarcfg_top sarcfg_chk #(.ResultWidth(ResultWidth)) i_sarcfg_chk (
  .core_clk, .reset_n, .clkEn, .regAddr, .regWrite, .regWdata, .regRead,
  .regRdata, .convDone, .rawResult, .conversionClockTick,
  .inputGainSelect, .eightBitModeEnable, .conversionBits);

// [tb/testbench.sv]
// Self-checking bench for the converter configuration block.
// Assumes design and checker compile first; inputs move at falling edges.
`timescale 1ns/100ps
module testbench;
  logic core_clk, reset_n = 1'b0, clkEn = 1'b1;
  logic regWrite = 1'b0, regRead = 1'b0, convDone = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, cfg, modes;
  logic [9:0] rawResult = 10'h000;
  logic [11:0] raw;
  logic [15:0] res;
  logic conversionClockTick, inputGainSelect, eightBitModeEnable;
  logic conversionClock, lastClk;
  logic [3:0] conversionBits;
  int n_mismatch = 0, n_checks = 0, cnt, rises;
  // Rows: configuration, raw result, expected high and low bytes.
  logic [35:0] rows [6] = '{36'h1_83ff_03ff, 36'h1_c3ff_ffc0,
    36'h1_c201_8040, 36'h1_a2c5_b100, 36'h1_e3ff_ff00, 36'h1_9155_0155};
  assign modes = {2'h0, eightBitModeEnable, inputGainSelect, conversionBits};
  sarcfg_top i_sarcfg_top (.core_clk, .reset_n, .clkEn, .regAddr,
    .regWrite, .regWdata, .regRead, .regRdata, .convDone, .rawResult,
    .conversionClock, .conversionClockTick, .inputGainSelect,
    .eightBitModeEnable, .conversionBits);
  task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // Strobes stay up until the next call, so each is set once per step.
  task automatic drv(logic [2:0] cwr, logic [7:0] a, logic [7:0] d);
    {convDone, regWrite, regRead} = cwr;
    regAddr = a;
    regWdata = d;
    @(negedge core_clk);
  endtask : drv
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (8) @(negedge core_clk);
    reset_n = 1'b1;
    foreach (rows[i])
    begin
      {cfg, raw, res} = rows[i];
      rawResult = raw[9:0];
      drv(3'b010, 8'hbc, cfg);
      drv(3'b100, 8'h00, 8'h00);
      drv(3'b001, 8'hbe, 8'h00);
      cmp("high", res[15:8], regRdata);
      drv(3'b001, 8'hbd, 8'h00);
      cmp("low", res[7:0], regRdata);
      drv(3'b001, 8'hbc, 8'h00);
      cmp("config", cfg, regRdata);
      cmp("mode", {2'h0, cfg[1:0], cfg[1] ? 4'h8 : 4'ha}, modes);
    end
    drv(3'b010, 8'hbe, 8'h55);
    drv(3'b001, 8'hbe, 8'h00);
    cmp("high rw", 8'h55, regRdata);
    rawResult = 10'h2aa;
    drv(3'b100, 8'h00, 8'h00);
    drv(3'b001, 8'hbe, 8'h00);
    cmp("high new", 8'h02, regRdata);
    drv(3'b001, 8'hbf, 8'h00);
    cmp("unmapped", 8'h00, regRdata);
    drv(3'b000, 8'h00, 8'h00);
    cnt = 0;
    rises = 0;
    lastClk = conversionClock;
    repeat (40)
    begin
      @(negedge core_clk);
      cnt += conversionClockTick;
      rises += conversionClock && !lastClk;
      lastClk = conversionClock;
    end
    cmp("ticks", 8'h0a, cnt[7:0]);
    cmp("clock rises", 8'h0a, rises[7:0]);
    // Nothing may move while the clock enable is low.
    clkEn = 1'b0;
    rawResult = 10'h155;
    drv(3'b110, 8'hbc, 8'h00);
    drv(3'b001, 8'hbe, 8'h00);
    cmp("frozen rdata", 8'h00, regRdata);
    clkEn = 1'b1;
    drv(3'b001, 8'hbc, 8'h00);
    cmp("frozen config", 8'h19, regRdata);
    drv(3'b001, 8'hbe, 8'h00);
    cmp("frozen high", 8'h02, regRdata);
    drv(3'b000, 8'h00, 8'h00);
    reset_n = 1'b0;
    repeat (8) @(negedge core_clk);
    reset_n = 1'b1;
    drv(3'b001, 8'hbc, 8'h00);
    cmp("config rst", 8'hf9, regRdata);
    drv(3'b001, 8'hbe, 8'h00);
    cmp("high rst", 8'h00, regRdata);
    drv(3'b001, 8'hbd, 8'h00);
    cmp("low rst", 8'h00, regRdata);
    drv(3'b000, 8'h00, 8'h00);
    cmp("mode rst", 8'h1a, modes);
    stop_test();
  end
endmodule : testbench
